// [src/sync_ctrl_defines.vh]
`ifndef SYNC_CTRL_DEFINES_VH
`define SYNC_CTRL_DEFINES_VH
// register indices on the plain port
`define ADDR_W            4
`define REG_CTRL          4'h0
`define REG_OPTS          4'h1
`define REG_MISS_MAX      4'h2
`define REG_CALC_NUM      4'h3
`define REG_TX_DIV        4'h4
`define REG_MAN_PERIOD    4'h5
`define REG_STATUS        4'h6
`define REG_IRQ_STAT      4'h7
`define REG_IRQ_MASK      4'h8
`define REG_MEAS_PERIOD   4'h9
`define REG_CMD           4'hA
// ctrl fields
`define CTRL_EN_BIT       0
`define CTRL_SEL_BIT      1
`define CTRL_RATE_LSB     4
`define CTRL_RATE_W       3
`define CTRL_RESET        8'h71
// option mask bits
`define OPT_BOOT          0
`define OPT_SYNC_PROD     2
`define OPT_AUTO_OP       3
`define OPT_AUTO_PER      4
`define OPTS_RESET        8'h00
`define MISS_MAX_RESET    8'h00
`define CALC_NUM_RESET    8'h05
`define TX_DIV_RESET      8'h05
`define MAN_PERIOD_RESET  32'h00000000
// cmd bits
`define CMD_START         0
`define CMD_INIT_DONE     1
// interrupt bits
`define IRQ_FAULT         0
`define IRQ_MEAS          1
`define IRQ_OPER          2
`define IRQ_W             3
// timing
`define CLK_MHZ           200
`define TICK_US           2000
`define TICK_CYCLES       (`TICK_US * `CLK_MHZ)
`define PERIOD_W          32
`endif

// [src/sync_tick_gen.v]
`timescale 1ns/1ps
`include "sync_ctrl_defines.vh"
// ----------------------------------------
// 2 ms tick divider
// ----------------------------------------
module sync_tick_gen #(
  parameter TICK_CYCLES = `TICK_CYCLES
) (
  input  wire clk,
  input  wire rstn,
  input  wire run,
  output reg  tick
);
  reg [19:0] cnt_r;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= 20'h00000;
      tick  <= 1'b0;
    end else if (!run) begin
      cnt_r <= 20'h00000;
      tick  <= 1'b0;
    end else if (cnt_r == TICK_CYCLES - 1) begin
      cnt_r <= 20'h00000;
      tick  <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 20'h00001;
      tick  <= 1'b0;
    end
  end
endmodule // sync_tick_gen

// [src/canopen_sync_startup_ctrl.v]
`timescale 1ns/1ps
`include "sync_ctrl_defines.vh"
// Contract
// - bit rate field selects one of eight rates, 10000 to 1000000 bit/s
// - one bit selects controller instance; instance zero is the default
// - enable bit gates all bus activity of the node
// - option bit 0 sends boot-up message after initialisation
// - option bit 2 makes this node the SYNC producer
// - option bit 3 enters operational alone; else wait start command
// - option bit 4 measures SYNC period from received SYNC spacing
// - fault after configured count of SYNC periods without SYNC
// - measurement averages a configurable number of received SYNC intervals
// - produced SYNC interval is divider times 2 ms
// - manual SYNC period used when measurement is off
module canopen_sync_startup_ctrl #(
  parameter TICK_CYCLES = `TICK_CYCLES
) (
  input  wire                  clk,
  input  wire                  rstn,
  input  wire [`ADDR_W-1:0]    addr,
  input  wire [31:0]           wdata,
  input  wire                  wr,
  input  wire                  rd,
  output reg  [31:0]           rdata,
  input  wire                  sync_rx,
  input  wire                  start_cmd,
  output reg                   can_en,
  output reg                   ctrl_sel,
  output reg  [19:0]           bit_rate_kbps_x10,
  output reg                   boot_tx,
  output reg                   sync_tx,
  output reg                   operational,
  output reg                   sync_fault,
  output wire                  irq
);
  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam ST_INIT = 3'b001;
  localparam ST_PREOP = 3'b010;
  localparam ST_OPER = 3'b100;

  reg [7:0]            ctrl_r;
  reg [7:0]            opts_r;
  reg [7:0]            miss_max_r;
  reg [7:0]            calc_num_r;
  reg [7:0]            tx_div_r;
  reg [`PERIOD_W-1:0]  man_period_r;
  reg [`PERIOD_W-1:0]  meas_period_r;
  reg [`IRQ_W-1:0]     irq_stat_r;
  reg [`IRQ_W-1:0]     irq_mask_r;
  reg [2:0]            state_r;
  reg [2:0]            state_nxt;
  reg                  init_done_r;
  reg                  start_r;
  reg [`PERIOD_W-1:0]  gap_cnt_r;
  reg [`PERIOD_W+7:0]  acc_r;
  reg [7:0]            acc_n_r;
  reg                  seen_r;
  reg [`PERIOD_W-1:0]  miss_cnt_r;
  reg [7:0]            miss_per_r;
  reg [7:0]            div_cnt_r;
  wire                 tick;
  wire                 en;
  wire [`PERIOD_W-1:0] period;
  wire                 auto_per;
  wire                 wr_cmd;
  wire                 sup_on;
  wire                 miss_wrap;
  wire                 miss_last;
  wire                 meas_last;
  wire [`PERIOD_W+7:0] avg_sum;
  wire [`PERIOD_W+7:0] avg_val;
  wire                 ev_fault;
  wire                 ev_meas;
  wire                 ev_oper;
  wire [`IRQ_W-1:0]    clr_bits;

  // ----------------------------------------
  // rate table
  // ----------------------------------------
  function [19:0] rate_lookup;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: rate_lookup = 20'h003E8;
        3'h1: rate_lookup = 20'h007D0;
        3'h2: rate_lookup = 20'h01388;
        3'h3: rate_lookup = 20'h030D4;
        3'h4: rate_lookup = 20'h061A8;
        3'h5: rate_lookup = 20'h0C350;
        3'h6: rate_lookup = 20'h13880;
        default: rate_lookup = 20'h186A0;
      endcase
    end
  endfunction

  // only bits 0, 2, 3, 4 are ever looked at
  assign en       = ctrl_r[`CTRL_EN_BIT];
  assign auto_per = opts_r[`OPT_AUTO_PER];
  assign period   = (auto_per && meas_period_r != 32'h00000000) ? meas_period_r : man_period_r;
  assign wr_cmd   = wr && (addr == `REG_CMD);

  // ----------------------------------------
  // event decode
  // ----------------------------------------
  // one decode feeds both the counters and the status bits, so they cannot drift apart
  assign sup_on    = period != 32'h00000000 && miss_max_r != 8'h00;
  assign miss_wrap = sup_on && !sync_rx && !sync_fault && miss_cnt_r + 32'h00000001 >= period;
  assign miss_last = miss_wrap && miss_per_r + 8'h01 >= miss_max_r;
  assign meas_last = sync_rx && auto_per && seen_r && calc_num_r != 8'h00 && acc_n_r + 8'h01 >= calc_num_r;
  // sum is 40 bits so a long run of long gaps cannot overflow before the divide
  assign avg_sum   = acc_r + {8'h00, gap_cnt_r};
  assign avg_val   = avg_sum / {32'h00000000, calc_num_r};
  assign ev_fault  = en && miss_last;
  assign ev_meas   = en && meas_last;
  assign ev_oper   = state_r != ST_OPER && state_nxt == ST_OPER;
  assign clr_bits  = (wr && addr == `REG_IRQ_STAT) ? wdata[`IRQ_W-1:0] : {`IRQ_W{1'b0}};

  sync_tick_gen #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk  (clk),
    .rstn (rstn),
    .run  (en),
    .tick (tick)
  );

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r       <= `CTRL_RESET;
      opts_r       <= `OPTS_RESET;
      miss_max_r   <= `MISS_MAX_RESET;
      calc_num_r   <= `CALC_NUM_RESET;
      tx_div_r     <= `TX_DIV_RESET;
      man_period_r <= `MAN_PERIOD_RESET;
      irq_mask_r   <= {`IRQ_W{1'b0}};
    end else if (wr) begin
      case (addr)
        `REG_CTRL:       ctrl_r <= wdata[7:0];
        `REG_OPTS:       opts_r <= wdata[7:0];
        `REG_MISS_MAX:   miss_max_r <= wdata[7:0];
        `REG_CALC_NUM:   calc_num_r <= wdata[7:0];
        `REG_TX_DIV:     tx_div_r <= wdata[7:0];
        `REG_MAN_PERIOD: man_period_r <= wdata;
        `REG_IRQ_MASK:   irq_mask_r <= wdata[`IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // node state machine
  // ----------------------------------------
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_INIT:  if (init_done_r) state_nxt = ST_PREOP;
      ST_PREOP: if (opts_r[`OPT_AUTO_OP] || start_r) state_nxt = ST_OPER;
      ST_OPER:  state_nxt = ST_OPER;
      default:  state_nxt = ST_INIT;
    endcase
    if (!en) state_nxt = ST_INIT;
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r     <= ST_INIT;
      init_done_r <= 1'b0;
      start_r     <= 1'b0;
      boot_tx     <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      init_done_r <= en && (init_done_r || (wr_cmd && wdata[`CMD_INIT_DONE]));
      // start request held until used; ignored while disabled
      start_r     <= en && state_r != ST_OPER &&
                     (start_r || start_cmd || (wr_cmd && wdata[`CMD_START]));
      boot_tx     <= en && opts_r[`OPT_BOOT] && state_r == ST_INIT && state_nxt == ST_PREOP;
    end
  end

  // ----------------------------------------
  // sync measurement and supervision
  // ----------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gap_cnt_r     <= 32'h00000000;
      acc_r         <= 40'h0000000000;
      acc_n_r       <= 8'h00;
      seen_r        <= 1'b0;
      meas_period_r <= 32'h00000000;
      miss_cnt_r    <= 32'h00000000;
      miss_per_r    <= 8'h00;
      sync_fault    <= 1'b0;
    end else if (!en) begin
      gap_cnt_r  <= 32'h00000000;
      acc_r      <= 40'h0000000000;
      acc_n_r    <= 8'h00;
      seen_r     <= 1'b0;
      miss_cnt_r <= 32'h00000000;
      miss_per_r <= 8'h00;
      sync_fault <= 1'b0;
    end else begin
      if (sync_rx) begin
        gap_cnt_r  <= 32'h00000001;
        seen_r     <= 1'b1;
        miss_cnt_r <= 32'h00000000;
        miss_per_r <= 8'h00;
        sync_fault <= 1'b0;
        if (auto_per && seen_r) begin
          // needs calc_num intervals; a count of zero never completes
          if (meas_last) begin
            meas_period_r <= avg_val[`PERIOD_W-1:0];
            acc_r         <= 40'h0000000000;
            acc_n_r       <= 8'h00;
          end else begin
            acc_r   <= avg_sum;
            acc_n_r <= acc_n_r + 8'h01;
          end
        end
      end else begin
        if (gap_cnt_r != 32'hFFFFFFFF) gap_cnt_r <= gap_cnt_r + 32'h00000001;
        // supervision runs only with a nonzero period and limit
        if (period != 32'h00000000 && miss_max_r != 8'h00 && !sync_fault) begin
          if (miss_cnt_r + 32'h00000001 >= period) begin
            miss_cnt_r <= 32'h00000000;
            miss_per_r <= miss_per_r + 8'h01;
            if (miss_last) sync_fault <= 1'b1;
          end else begin
            miss_cnt_r <= miss_cnt_r + 32'h00000001;
          end
        end
      end
    end
  end

  // ----------------------------------------
  // sync production
  // ----------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_cnt_r <= 8'h00;
      sync_tx   <= 1'b0;
    end else begin
      sync_tx <= 1'b0;
      if (!en || !opts_r[`OPT_SYNC_PROD] || tx_div_r == 8'h00) begin
        div_cnt_r <= 8'h00;
      end else if (tick) begin
        if (div_cnt_r + 8'h01 >= tx_div_r) begin
          div_cnt_r <= 8'h00;
          sync_tx   <= 1'b1;
        end else begin
          div_cnt_r <= div_cnt_r + 8'h01;
        end
      end
    end
  end

  // ----------------------------------------
  // outputs and interrupts
  // ----------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      can_en            <= 1'b0;
      ctrl_sel          <= 1'b0;
      bit_rate_kbps_x10 <= 20'h186A0;
      operational       <= 1'b0;
      irq_stat_r        <= {`IRQ_W{1'b0}};
    end else begin
      can_en            <= en;
      ctrl_sel          <= ctrl_r[`CTRL_SEL_BIT];
      bit_rate_kbps_x10 <= rate_lookup(ctrl_r[`CTRL_RATE_LSB +: `CTRL_RATE_W]);
      operational       <= state_r == ST_OPER;
      // a new event wins over a same-cycle clear
      irq_stat_r <= (irq_stat_r & ~clr_bits) | {ev_oper, ev_meas, ev_fault};
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  // ----------------------------------------
  // register reads
  // ----------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 32'h00000000;
    end else if (rd) begin
      case (addr)
        `REG_CTRL:        rdata <= {24'h000000, ctrl_r};
        `REG_OPTS:        rdata <= {24'h000000, opts_r};
        `REG_MISS_MAX:    rdata <= {24'h000000, miss_max_r};
        `REG_CALC_NUM:    rdata <= {24'h000000, calc_num_r};
        `REG_TX_DIV:      rdata <= {24'h000000, tx_div_r};
        `REG_MAN_PERIOD:  rdata <= man_period_r;
        `REG_STATUS:      rdata <= {26'h0000000, seen_r, sync_fault, 1'b0, state_r};
        `REG_IRQ_STAT:    rdata <= {29'h00000000, irq_stat_r};
        `REG_IRQ_MASK:    rdata <= {29'h00000000, irq_mask_r};
        `REG_MEAS_PERIOD: rdata <= meas_period_r;
        default:          rdata <= 32'h00000000;
      endcase
    end else begin
      rdata <= 32'h00000000;
    end
  end
endmodule // canopen_sync_startup_ctrl

// [bench/net_peer.sv]
`timescale 1ns/1ps
// ----------------------------------------
// network side: sync producer and master
// ----------------------------------------
module net_peer (
  input  wire        clk,
  input  wire        rstn,
  input  wire [15:0] gap,
  input  wire        go_start,
  output reg         sync_rx,
  output reg         start_cmd
);
  reg [15:0] cnt_r;
  // spacing is gap plus one; gap zero sends no SYNC
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r     <= 16'h0000;
      sync_rx   <= 1'b0;
      start_cmd <= 1'b0;
    end else begin
      start_cmd <= go_start;
      sync_rx   <= (gap != 16'h0000) && (cnt_r == 16'h0000);
      cnt_r     <= (cnt_r == 16'h0000) ? gap : cnt_r - 16'h0001;
    end
  end
endmodule // net_peer

// [bench/canopen_sync_startup_ctrl_asserts.sv]
`timescale 1ns/1ps
`include "sync_ctrl_defines.vh"
module sync_ctrl_checker #(
  parameter TICK_CYCLES = 20
) (
  input wire        clk,
  input wire        rstn,
  input wire [3:0]  addr,
  input wire        wr,
  input wire        rd,
  input wire [31:0] rdata,
  input wire        sync_rx,
  input wire        can_en,
  input wire        ctrl_sel,
  input wire [19:0] bit_rate_kbps_x10,
  input wire        boot_tx,
  input wire        sync_tx,
  input wire        operational,
  input wire        sync_fault
);
  reg [31:0] since_r;
  reg        cw1_r;
  reg        cw2_r;
  // output may follow a ctrl write by one or two edges
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      since_r <= 32'h0000FFFF;
      cw1_r   <= 1'b0;
      cw2_r   <= 1'b0;
    end else begin
      cw1_r   <= wr && (addr == `REG_CTRL);
      cw2_r   <= cw1_r;
      if (sync_tx) since_r <= 32'h00000001;
      else if (since_r != 32'h0000FFFF) since_r <= since_r + 32'h00000001;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("rdata not zero outside read slot");
  chk_rate_legal: assert property (bit_rate_kbps_x10 inside {20'h003E8, 20'h007D0, 20'h01388, 20'h030D4,
    20'h061A8, 20'h0C350, 20'h13880, 20'h186A0}) else $error("bit rate outside set");
  chk_rate_write: assert property ($changed(bit_rate_kbps_x10) |-> cw1_r || cw2_r)
    else $error("bit rate moved without ctrl write");
  chk_sel_write: assert property ($changed(ctrl_sel) |-> cw1_r || cw2_r)
    else $error("controller select moved without ctrl write");
  chk_off_quiet: assert property (!can_en && !$past(can_en) |-> !(operational | sync_tx | boot_tx | sync_fault))
    else $error("activity while disabled");
  chk_boot_pulse: assert property (boot_tx |=> !boot_tx)
    else $error("boot pulse too long");
  chk_sync_pulse: assert property (sync_tx |=> !sync_tx)
    else $error("sync pulse too long");
  chk_sync_space: assert property (sync_tx |-> since_r >= TICK_CYCLES)
    else $error("sync sent closer than one tick");
  chk_oper_enabled: assert property ($rose(operational) |-> can_en && $past(can_en))
    else $error("operational while disabled");
  chk_fault_clear: assert property (sync_fault && sync_rx |-> ##[1:2] !sync_fault)
    else $error("fault kept after sync");
endmodule // sync_ctrl_checker
bind canopen_sync_startup_ctrl sync_ctrl_checker #(.TICK_CYCLES(TICK_CYCLES)) i_chk (.clk(clk), .rstn(rstn),
  .addr(addr), .wr(wr), .rd(rd), .rdata(rdata), .sync_rx(sync_rx), .can_en(can_en), .ctrl_sel(ctrl_sel),
  .bit_rate_kbps_x10(bit_rate_kbps_x10), .boot_tx(boot_tx), .sync_tx(sync_tx), .operational(operational),
  .sync_fault(sync_fault));

// [bench/canopen_sync_startup_ctrl_bench.sv]
`timescale 1ns/1ps
`include "sync_ctrl_defines.vh"
module canopen_sync_startup_ctrl_bench;
  localparam TICK = 20;
  localparam [19:0] RATES [0:7] = '{20'h003E8, 20'h007D0, 20'h01388, 20'h030D4,
                                    20'h061A8, 20'h0C350, 20'h13880, 20'h186A0};
  reg         clk, rstn, wr, rd, go_start;
  reg         rd_d = 1'b0;
  reg  [3:0]  addr;
  reg  [31:0] wdata;
  reg  [15:0] gap;
  wire [31:0] rdata;
  wire [19:0] rate;
  wire        sync_rx, start_cmd, can_en, ctrl_sel, boot_tx, sync_tx, operational, sync_fault, irq;
  wire [4:0]  mon = {irq, sync_fault, operational, sync_tx, boot_tx};
  integer     num_errors, checks, seed, i, n, t;
  reg  [31:0] exp_q [$];

  canopen_sync_startup_ctrl #(.TICK_CYCLES(TICK)) i_dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .sync_rx(sync_rx), .start_cmd(start_cmd), .can_en(can_en),
    .ctrl_sel(ctrl_sel), .bit_rate_kbps_x10(rate), .boot_tx(boot_tx), .sync_tx(sync_tx),
    .operational(operational), .sync_fault(sync_fault), .irq(irq));
  net_peer i_peer (.clk(clk), .rstn(rstn), .gap(gap), .go_start(go_start), .sync_rx(sync_rx),
    .start_cmd(start_cmd));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task check(input [31:0] seen, input [31:0] exp, input string nm);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("wrong value %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task results;
    begin
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  task wreg(input [3:0] a, input [31:0] d);
    begin
      wr <= 1'b1; addr <= a; wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
    end
  endtask
  task rreg(input [3:0] a, input [31:0] e);
    begin
      exp_q.push_back(e);
      rd <= 1'b1; addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
    end
  endtask
  // bounded wait on one watched output, cycles waited in t
  task wait_hi(input integer s, input integer lim);
    begin
      t = 0;
      while (mon[s] !== 1'b1 && t < lim) begin
        @(posedge clk);
        t = t + 1;
      end
    end
  endtask
  always @(posedge clk) begin
    if (rd_d) check(rdata, exp_q.pop_front(), "rdata");
    rd_d <= rd;
  end
  initial begin
    #100000;
    num_errors = num_errors + 1;
    results;
  end
  initial begin
    seed = 72234; num_errors = 0; checks = 0; rstn = 1'b0; wr = 1'b0; rd = 1'b0;
    addr = 4'h0; wdata = 32'h0; gap = 16'h0; go_start = 1'b0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    check(rate, 32'h186A0, "reset rate");
    rreg(`REG_CTRL, 32'h71); rreg(`REG_OPTS, 32'h0); rreg(`REG_MISS_MAX, 32'h0);
    rreg(`REG_CALC_NUM, 32'h5); rreg(`REG_TX_DIV, 32'h5); rreg(`REG_MAN_PERIOD, 32'h0);
    rreg(4'hF, 32'h0);
    check(can_en, 1'b1, "can_en");
    for (i = 0; i < 8; i = i + 1) begin
      n = $random(seed) & 1;
      wreg(`REG_CTRL, (i << 4) | (n << 1) | 1);
      repeat (3) @(posedge clk);
      check(rate, RATES[i], "bit rate");
      check(ctrl_sel, n, "ctrl_sel");
    end
    wreg(`REG_CTRL, 32'h71); wreg(`REG_IRQ_MASK, 32'h4);
    n = $random(seed) & 32'hE2;
    wreg(`REG_OPTS, n | 32'h09); rreg(`REG_OPTS, n | 32'h09);
    wreg(`REG_CMD, 32'h2);
    wait_hi(0, 20); check(t < 20, 1, "boot_tx");
    wait_hi(2, 20); check(t < 20, 1, "auto operational");
    repeat (2) @(posedge clk);
    check(irq, 1, "oper irq"); rreg(`REG_IRQ_STAT, 32'h4);
    wreg(`REG_IRQ_STAT, 32'h4); repeat (2) @(posedge clk);
    check(irq, 0, "irq cleared");
    wreg(`REG_CTRL, 32'h70); repeat (3) @(posedge clk);
    check({can_en, operational}, 2'b00, "disabled");
    wreg(`REG_CTRL, 32'h71); wreg(`REG_OPTS, 32'h0); wreg(`REG_CMD, 32'h2);
    wait_hi(0, 10); check(t, 10, "no boot");
    check(operational, 0, "waits start");
    go_start <= 1'b1; @(posedge clk); go_start <= 1'b0;
    wait_hi(2, 10); check(t < 10, 1, "started");
    wreg(`REG_OPTS, 32'h4);
    for (i = 1; i < 4; i = i + 2) begin
      wreg(`REG_TX_DIV, i);
      wait_hi(1, 300); @(posedge clk);
      wait_hi(1, 300); check(t + 1, i * TICK, "sync gap");
    end
    wreg(`REG_OPTS, 32'h0); wreg(`REG_MAN_PERIOD, 32'h1E); wreg(`REG_MISS_MAX, 32'h2);
    wreg(`REG_IRQ_MASK, 32'h1); gap <= 16'h18;
    wait_hi(3, 200); check(t, 200, "no fault");
    gap <= 16'h0;
    wait_hi(3, 100); check(t >= 30 && t <= 70, 1, "fault time");
    gap <= 16'h18; repeat (4) @(posedge clk);
    check({irq, sync_fault}, 2'b10, "fault cleared");
    wreg(`REG_MISS_MAX, 32'h0); wreg(`REG_IRQ_STAT, 32'h7); wreg(`REG_CALC_NUM, 32'h2);
    wreg(`REG_IRQ_MASK, 32'h2); gap <= 16'h27;
    repeat (50) @(posedge clk);
    wreg(`REG_OPTS, 32'h10);
    wait_hi(4, 300); check(t < 300, 1, "measure irq");
    rreg(`REG_MEAS_PERIOD, 32'h28);
    repeat (2) @(posedge clk);
    results;
  end
endmodule // canopen_sync_startup_ctrl_bench
